// file: srd_pkg.sv
/*
  srd_pkg: opcode patterns, field positions, clock counts and carrier
  structs for the shift/rotate decoder. Assumes a byte-aligned fetch stream.
*/
`default_nettype none
package srd_pkg;
  localparam logic [7:0] SRD_ESC_BYTE = 8'h0F;
  localparam logic [6:0] SRD_GRP_BY1 = 7'h68;
  localparam logic [6:0] SRD_GRP_BYCNT = 7'h69;
  localparam logic [6:0] SRD_GRP_BYIMM = 7'h60;
  localparam logic [7:0] SRD_DSL_IMM = 8'hA4;
  localparam logic [7:0] SRD_DSL_CNT = 8'hA5;
  localparam logic [7:0] SRD_DSR_IMM = 8'hAC;
  localparam logic [7:0] SRD_DSR_CNT = 8'hAD;
  localparam logic [5:0] SRD_AND_PAT = 6'h08;
  localparam logic [1:0] SRD_MOD_REG = 2'h3;
  localparam int SRD_MOD_HI = 7;
  localparam int SRD_MOD_LO = 6;
  localparam int SRD_REG_HI = 5;
  localparam int SRD_REG_LO = 3;
  localparam int SRD_RM_HI = 2;
  localparam int SRD_RM_LO = 0;
  localparam int SRD_COUNT_W = 5;
  localparam logic [3:0] SRD_CLK_SH_REG = 4'h3;
  localparam logic [3:0] SRD_CLK_SH_MEM = 4'h7;
  localparam logic [3:0] SRD_CLK_RC_REG = 4'h9;
  localparam logic [3:0] SRD_CLK_RC_MEM = 4'hA;
  localparam logic [3:0] SRD_CLK_AND = 4'h2;
  localparam logic [3:0] SRD_CLK_RST = 4'h0;

  typedef enum logic [3:0] {
    SRD_OP_NONE, SRD_OP_ROTATE_LEFT, SRD_OP_ROTATE_RIGHT,
    SRD_OP_ROTATE_LEFT_VIA_CARRY, SRD_OP_ROTATE_RIGHT_VIA_CARRY,
    SRD_OP_SHIFT_LEFT, SRD_OP_LOGICAL_SHIFT_RIGHT, SRD_OP_ARITH_SHIFT_RIGHT,
    SRD_OP_DOUBLE_SHIFT_LEFT, SRD_OP_DOUBLE_SHIFT_RIGHT, SRD_OP_AND
  } srd_op_e;

  typedef enum logic [1:0] {
    SRD_CNT_ONE, SRD_CNT_REG, SRD_CNT_IMM
  } srd_cnt_e;

  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } srd_fetch_s;

  typedef struct packed {
    srd_op_e op;
    srd_cnt_e cnt_src;
    logic [SRD_COUNT_W-1:0] count;
    logic mem_operand;
    logic wide;
    logic dir_to_reg;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic [3:0] clocks;
    logic [2:0] length;
  } srd_decode_s;
endpackage : srd_pkg
`default_nettype wire

// file: srd_count_mask.sv
/*
  srd_count_mask: picks the shift count source and trims it to five bits.
  Assumes the count register value is presented already read from the file.
*/
`timescale 1ns/1ps
`default_nettype none
module srd_count_mask (
  // count sources
  input wire srd_pkg::srd_cnt_e i_cnt_src,
  input wire logic [7:0] i_imm_count,
  input wire logic [7:0] i_count_register,
  // masked count
  output logic [srd_pkg::SRD_COUNT_W-1:0] o_count
);
  import srd_pkg::*;

  always_comb begin
    unique case (i_cnt_src)
      SRD_CNT_ONE: o_count = SRD_COUNT_W'(1);
      SRD_CNT_REG: o_count = i_count_register[SRD_COUNT_W-1:0];
      SRD_CNT_IMM: o_count = i_imm_count[SRD_COUNT_W-1:0];
      default: o_count = '0;
    endcase
  end
endmodule : srd_count_mask
`default_nettype wire

// file: srd_decoder.sv
/*
  srd_decoder: decodes the shift/rotate group, double shifts and register
  AND, and registers the operation with its execution clock count.
  Assumes fetch presents up to four aligned instruction bytes with a valid.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Opcodes 1101000w, 1101001w, 1100000w: shift by one, count register, immediate byte.
// - modrm reg field picks rotate, carry rotate, left, logical or arithmetic right.
// - Plain rotates and shifts take 3 clocks register, 7 clocks memory.
// - Rotates through carry take 9 clocks register, 10 clocks memory.
// - 0F A4 with modrm and immediate is double left shift, 3/7 clocks.
// - 0F A5 is double left shift by count register, same timing.
// - 0F AC with modrm and immediate is double right shift, 3/7 clocks.
// - 0F AD is double right shift by count register, same timing.
// - 001000dw with register modrm is register AND, 2 clocks, d/w used.
module srd_decoder (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // fetch side
  input wire logic i_valid,
  input wire srd_pkg::srd_fetch_s i_fetch,
  input wire logic [7:0] i_count_register,
  // decoded result
  output logic o_valid,
  output logic o_illegal,
  output srd_pkg::srd_decode_s o_decode
);
  import srd_pkg::*;

  logic valid_q, valid_d;
  logic illegal_q, illegal_d;
  srd_decode_s dec_q, dec_d;
  srd_decode_s dec_c;
  logic hit_c;
  logic [7:0] modrm_c;
  logic [7:0] imm_c;
  logic [4:0] count_c;
  logic is_esc_c, is_grp_c, is_and_c;
  srd_cnt_e cnt_src_c;

  srd_count_mask u_count_mask (
    .i_cnt_src(cnt_src_c),
    .i_imm_count(imm_c),
    .i_count_register(i_count_register),
    .o_count(count_c)
  );

  // byte positions and count source settle ahead of the count mask, so the
  // masked count never feeds back into the process that picks its source
  always_comb begin
    is_esc_c = i_fetch.byte0 == SRD_ESC_BYTE;
    is_grp_c = i_fetch.byte0[7:1] == SRD_GRP_BY1 || i_fetch.byte0[7:1] == SRD_GRP_BYCNT ||
               i_fetch.byte0[7:1] == SRD_GRP_BYIMM;
    is_and_c = i_fetch.byte0[7:2] == SRD_AND_PAT;
    modrm_c = i_fetch.byte1;
    imm_c = i_fetch.byte2;
    cnt_src_c = SRD_CNT_ONE;
    if (is_esc_c) begin
      modrm_c = i_fetch.byte2;
      imm_c = i_fetch.byte3;
      if (i_fetch.byte1 == SRD_DSL_IMM || i_fetch.byte1 == SRD_DSR_IMM) begin
        cnt_src_c = SRD_CNT_IMM;
      end else begin
        cnt_src_c = SRD_CNT_REG;
      end
    end else if (i_fetch.byte0[7:1] == SRD_GRP_BYCNT) begin
      cnt_src_c = SRD_CNT_REG;
    end else if (i_fetch.byte0[7:1] == SRD_GRP_BYIMM) begin
      cnt_src_c = SRD_CNT_IMM;
    end
  end

  // classify opcode
  always_comb begin
    dec_c = '0;
    dec_c.op = SRD_OP_NONE;
    dec_c.cnt_src = cnt_src_c;
    hit_c = 1'b0;
    if (is_esc_c) begin
      unique case (i_fetch.byte1)
        SRD_DSL_IMM: begin
          dec_c.op = SRD_OP_DOUBLE_SHIFT_LEFT;
          dec_c.cnt_src = SRD_CNT_IMM;
          dec_c.length = 3'd4;
          hit_c = 1'b1;
        end
        SRD_DSL_CNT: begin
          dec_c.op = SRD_OP_DOUBLE_SHIFT_LEFT;
          dec_c.cnt_src = SRD_CNT_REG;
          dec_c.length = 3'd3;
          hit_c = 1'b1;
        end
        SRD_DSR_IMM: begin
          dec_c.op = SRD_OP_DOUBLE_SHIFT_RIGHT;
          dec_c.cnt_src = SRD_CNT_IMM;
          dec_c.length = 3'd4;
          hit_c = 1'b1;
        end
        SRD_DSR_CNT: begin
          dec_c.op = SRD_OP_DOUBLE_SHIFT_RIGHT;
          dec_c.cnt_src = SRD_CNT_REG;
          dec_c.length = 3'd3;
          hit_c = 1'b1;
        end
        default: hit_c = 1'b0;
      endcase
    end else if (is_grp_c) begin
      // count source from opcode form
      if (i_fetch.byte0[7:1] == SRD_GRP_BY1) begin
        dec_c.cnt_src = SRD_CNT_ONE;
        dec_c.length = 3'd2;
      end else if (i_fetch.byte0[7:1] == SRD_GRP_BYCNT) begin
        dec_c.cnt_src = SRD_CNT_REG;
        dec_c.length = 3'd2;
      end else begin
        dec_c.cnt_src = SRD_CNT_IMM;
        dec_c.length = 3'd3;
      end
      dec_c.wide = i_fetch.byte0[0];
      hit_c = 1'b1;
      unique case (modrm_c[SRD_REG_HI:SRD_REG_LO])
        3'h0: dec_c.op = SRD_OP_ROTATE_LEFT;
        3'h1: dec_c.op = SRD_OP_ROTATE_RIGHT;
        3'h2: dec_c.op = SRD_OP_ROTATE_LEFT_VIA_CARRY;
        3'h3: dec_c.op = SRD_OP_ROTATE_RIGHT_VIA_CARRY;
        3'h4: dec_c.op = SRD_OP_SHIFT_LEFT;
        3'h5: dec_c.op = SRD_OP_LOGICAL_SHIFT_RIGHT;
        3'h7: dec_c.op = SRD_OP_ARITH_SHIFT_RIGHT;
        default: hit_c = 1'b0; // code 110 left undefined
      endcase
    end else if (is_and_c && modrm_c[SRD_MOD_HI:SRD_MOD_LO] == SRD_MOD_REG) begin
      dec_c.op = SRD_OP_AND;
      dec_c.dir_to_reg = i_fetch.byte0[1];
      dec_c.wide = i_fetch.byte0[0];
      dec_c.length = 3'd2;
      hit_c = 1'b1;
    end
    // double shifts are always full width
    if (dec_c.op == SRD_OP_DOUBLE_SHIFT_LEFT || dec_c.op == SRD_OP_DOUBLE_SHIFT_RIGHT) begin
      dec_c.wide = 1'b1;
    end
    dec_c.mem_operand = modrm_c[SRD_MOD_HI:SRD_MOD_LO] != SRD_MOD_REG;
    dec_c.reg_field = modrm_c[SRD_REG_HI:SRD_REG_LO];
    dec_c.rm_field = modrm_c[SRD_RM_HI:SRD_RM_LO];
    dec_c.count = (dec_c.op == SRD_OP_AND) ? '0 : count_c;
    // timing depends only on op and operand kind, never the count
    unique case (dec_c.op)
      SRD_OP_ROTATE_LEFT_VIA_CARRY, SRD_OP_ROTATE_RIGHT_VIA_CARRY:
        dec_c.clocks = dec_c.mem_operand ? SRD_CLK_RC_MEM : SRD_CLK_RC_REG;
      SRD_OP_AND: dec_c.clocks = SRD_CLK_AND;
      SRD_OP_NONE: dec_c.clocks = SRD_CLK_RST;
      default: dec_c.clocks = dec_c.mem_operand ? SRD_CLK_SH_MEM : SRD_CLK_SH_REG;
    endcase
    if (!hit_c) begin
      dec_c.op = SRD_OP_NONE;
      dec_c.clocks = SRD_CLK_RST;
    end
  end

  // next-state
  always_comb begin
    valid_d = i_valid && hit_c;
    illegal_d = i_valid && !hit_c;
    dec_d = i_valid ? dec_c : dec_q;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      valid_q <= 1'b0;
      illegal_q <= 1'b0;
      dec_q <= '0;
    end else begin
      valid_q <= valid_d;
      illegal_q <= illegal_d;
      dec_q <= dec_d;
    end
  end

  assign o_valid = valid_q;
  assign o_illegal = illegal_q;
  assign o_decode = dec_q;
endmodule : srd_decoder
`default_nettype wire

// file: srd_decoder_chk.sv
/* srd_decoder_chk: port assertions for the decoder.
  Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module srd_decoder_chk (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // watched ports
  input wire logic i_valid,
  input wire srd_pkg::srd_fetch_s i_fetch,
  input wire logic [7:0] i_count_register,
  input wire logic o_valid,
  input wire logic o_illegal,
  input wire srd_pkg::srd_decode_s o_decode
);
  import srd_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  wire logic [7:0] b0 = i_fetch.byte0;
  wire logic [2:0] sub = i_fetch.byte1[5:3];
  wire logic r1 = i_fetch.byte1[7:6] == SRD_MOD_REG;
  wire logic r2 = i_fetch.byte2[7:6] == SRD_MOD_REG;
  wire logic [4:0] cr5 = i_count_register[4:0];
  wire logic [4:0] im5 = i_fetch.byte2[4:0];
  wire logic grp = i_valid && sub != 3'h6 &&
    (b0[7:1] inside {SRD_GRP_BY1, SRD_GRP_BYCNT, SRD_GRP_BYIMM});
  wire logic dbl = i_valid && b0 == SRD_ESC_BYTE &&
    (i_fetch.byte1 inside {SRD_DSL_IMM, SRD_DSL_CNT, SRD_DSR_IMM, SRD_DSR_CNT});
  sequence s_pass;
    o_valid && !o_illegal;
  endsequence
  chk_one_answer: assert property (i_valid |=> o_valid != o_illegal)
    else $error("no single answer");
  chk_idle_hold: assert property (!i_valid |=> !o_valid && !o_illegal && $stable(o_decode))
    else $error("idle output moved");
  chk_shift_clocks: assert property (grp && sub[2:1] != 2'h1 |=> s_pass ##0
    o_decode.clocks == ($past(r1) ? 4'h3 : 4'h7)) else $error("shift clocks");
  chk_carry_clocks: assert property (grp && sub[2:1] == 2'h1 |=> s_pass ##0
    o_decode.clocks == ($past(r1) ? 4'h9 : 4'hA)) else $error("carry clocks");
  chk_double_clocks: assert property (dbl |=> s_pass ##0
    o_decode.clocks == ($past(r2) ? 4'h3 : 4'h7)) else $error("double clocks");
  chk_and_decode: assert property (i_valid && b0[7:2] == SRD_AND_PAT && r1 |=> s_pass ##0
    o_decode.op == SRD_OP_AND && o_decode.clocks == 4'h2) else $error("and decode");
  chk_one_count: assert property (grp && b0[7:1] == SRD_GRP_BY1 |=>
    o_decode.count == 5'h01) else $error("by-one count");
  chk_reg_count: assert property (grp && b0[7:1] == SRD_GRP_BYCNT |=>
    o_decode.count == $past(cr5)) else $error("register count");
  chk_imm_count: assert property (grp && b0[7:1] == SRD_GRP_BYIMM |=>
    o_decode.count == $past(im5)) else $error("immediate count");
  chk_illegal_blank: assert property (o_illegal |-> o_decode.op == SRD_OP_NONE &&
    o_decode.clocks == SRD_CLK_RST) else $error("illegal decode not blank");
endmodule : srd_decoder_chk
bind srd_decoder srd_decoder_chk i_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_valid(i_valid), .i_fetch(i_fetch), .i_count_register(i_count_register),
  .o_valid(o_valid), .o_illegal(o_illegal), .o_decode(o_decode));
`default_nettype wire

// file: shift_rotate_decode_timing_tb.sv
/* shift_rotate_decode_timing_tb: directed decode and timing tests.
  Assumes the checker is bound alongside. */
`timescale 1ns/1ps
`default_nettype none
module shift_rotate_decode_timing_tb;
  import srd_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_valid = 1'b0;
  srd_fetch_s i_fetch = '0;
  logic [7:0] i_count_register = 8'h00;
  logic o_valid;
  logic o_illegal;
  srd_decode_s o_decode;
  int errors = 0;
  int checked = 0;
  srd_op_e tbl [8] = '{SRD_OP_ROTATE_LEFT, SRD_OP_ROTATE_RIGHT, SRD_OP_ROTATE_LEFT_VIA_CARRY,
    SRD_OP_ROTATE_RIGHT_VIA_CARRY, SRD_OP_SHIFT_LEFT, SRD_OP_LOGICAL_SHIFT_RIGHT,
    SRD_OP_NONE, SRD_OP_ARITH_SHIFT_RIGHT};
  srd_decoder i_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_valid(i_valid),
    .i_fetch(i_fetch), .i_count_register(i_count_register), .o_valid(o_valid),
    .o_illegal(o_illegal), .o_decode(o_decode));
  always #12.5 i_sys_clk = ~i_sys_clk;
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // drive on a falling edge, judge at the next one; calls chain back to back
  task automatic xfer(input logic [31:0] f, input logic [7:0] cr, input logic ok,
    input srd_op_e op, input logic [3:0] clk, input logic [4:0] cnt);
    i_valid = 1'b1;
    i_fetch = f;
    i_count_register = cr;
    @(negedge i_sys_clk);
    cmp("valid", 8'(ok), 8'(o_valid));
    cmp("illegal", 8'(!ok), 8'(o_illegal));
    cmp("op", 8'(op), 8'(o_decode.op));
    cmp("clocks", 8'(clk), 8'(o_decode.clocks));
    if (ok) cmp("count", 8'(cnt), 8'(o_decode.count));
  endtask : xfer
  // operand fields beside op, timing and count, judged while the decode stands
  task automatic fields(input logic [2:0] len, input srd_cnt_e src, input logic mem,
    input logic wd, input logic [2:0] rf, input logic [2:0] rm);
    cmp("length", 8'(len), 8'(o_decode.length));
    cmp("cnt_src", 8'(src), 8'(o_decode.cnt_src));
    cmp("mem", 8'(mem), 8'(o_decode.mem_operand));
    cmp("wide", 8'(wd), 8'(o_decode.wide));
    cmp("reg_field", 8'(rf), 8'(o_decode.reg_field));
    cmp("rm_field", 8'(rm), 8'(o_decode.rm_field));
  endtask : fields
  task automatic t_sub_ops;
    for (int m = 0; m < 2; m++) begin
      for (int r = 0; r < 8; r++) begin
        xfer({8'hD1, m ? 2'h0 : 2'h3, 3'(r), 3'h1, 16'h0}, 8'h00, r != 6,
          tbl[r], r == 6 ? 4'h0 :
          (r inside {2, 3}) ? (m ? 4'hA : 4'h9) : (m ? 4'h7 : 4'h3), 5'h01);
        if (r != 6) fields(3'h2, SRD_CNT_ONE, 1'(m), 1'b1, 3'(r), 3'h1);
      end
    end
  endtask : t_sub_ops
  task automatic t_counts;
    xfer({8'hD3, 8'hE0, 16'h0}, 8'hE5, 1'b1, SRD_OP_SHIFT_LEFT, 4'h3, 5'h05);
    fields(3'h2, SRD_CNT_REG, 1'b0, 1'b1, 3'h4, 3'h0);
    xfer({8'hC1, 8'hD0, 8'h3F, 8'h0}, 8'h00, 1'b1, tbl[2], 4'h9, 5'h1F);
    fields(3'h3, SRD_CNT_IMM, 1'b0, 1'b1, 3'h2, 3'h0);
    xfer({8'hC0, 8'h18, 8'h21, 8'h0}, 8'hFF, 1'b1, tbl[3], 4'hA, 5'h01);
    fields(3'h3, SRD_CNT_IMM, 1'b1, 1'b0, 3'h3, 3'h0);
    xfer({8'hD2, 8'h38, 16'h0}, 8'h20, 1'b1, tbl[7], 4'h7, 5'h00);
    fields(3'h2, SRD_CNT_REG, 1'b1, 1'b0, 3'h7, 3'h0);
  endtask : t_counts
  // mid-run reset with a request pending: it is dropped and every output clears
  task automatic t_reset;
    i_reset = 1'b1;
    i_valid = 1'b1;
    i_fetch = {8'hD1, 8'hC0, 16'h0};
    @(negedge i_sys_clk);
    cmp("reset valid", 8'h00, 8'(o_valid));
    cmp("reset illegal", 8'h00, 8'(o_illegal));
    cmp("reset op", 8'(SRD_OP_NONE), 8'(o_decode.op));
    cmp("reset clocks", 8'(SRD_CLK_RST), 8'(o_decode.clocks));
    cmp("reset decode", 8'h00, 8'(o_decode != '0));
    i_reset = 1'b0;
    xfer({8'hD1, 8'hC0, 16'h0}, 8'h00, 1'b1, SRD_OP_ROTATE_LEFT, 4'h3, 5'h01);
  endtask : t_reset
  task automatic t_and;
    for (int d = 0; d < 4; d++) begin
      xfer({6'h08, 2'(d), 8'hC8, 16'h0}, 8'h00, 1'b1, SRD_OP_AND, 4'h2, 5'h00);
      cmp("wide", 8'(d % 2), 8'(o_decode.wide));
      cmp("dir", 8'(d / 2), 8'(o_decode.dir_to_reg));
      cmp("and regs", 8'h08, 8'({o_decode.reg_field, o_decode.rm_field}));
      cmp("and length", 8'h02, 8'(o_decode.length));
    end
    xfer({8'h21, 8'h08, 16'h0}, 8'h00, 1'b0, SRD_OP_NONE, 4'h0, 5'h00);
    xfer({8'h90, 24'h0}, 8'h00, 1'b0, SRD_OP_NONE, 4'h0, 5'h00);
    xfer({8'h0F, 8'hAF, 8'hC0, 8'h00}, 8'h00, 1'b0, SRD_OP_NONE, 4'h0, 5'h00);
  endtask : t_and
  task automatic t_double;
    xfer({8'h0F, 8'hA4, 8'hC1, 8'h2A}, 8'h00, 1'b1,
      SRD_OP_DOUBLE_SHIFT_LEFT, 4'h3, 5'h0A);
    fields(3'h4, SRD_CNT_IMM, 1'b0, 1'b1, 3'h0, 3'h1);
    xfer({8'h0F, 8'hA5, 8'h01, 8'h00}, 8'h3E, 1'b1,
      SRD_OP_DOUBLE_SHIFT_LEFT, 4'h7, 5'h1E);
    fields(3'h3, SRD_CNT_REG, 1'b1, 1'b1, 3'h0, 3'h1);
    xfer({8'h0F, 8'hAC, 8'h06, 8'h07}, 8'h00, 1'b1,
      SRD_OP_DOUBLE_SHIFT_RIGHT, 4'h7, 5'h07);
    fields(3'h4, SRD_CNT_IMM, 1'b1, 1'b1, 3'h0, 3'h6);
    xfer({8'h0F, 8'hAD, 8'hD8, 8'h00}, 8'h61, 1'b1,
      SRD_OP_DOUBLE_SHIFT_RIGHT, 4'h3, 5'h01);
    fields(3'h3, SRD_CNT_REG, 1'b0, 1'b1, 3'h3, 3'h0);
    i_valid = 1'b0;
    @(negedge i_sys_clk);
    cmp("idle valid", 8'h00, 8'(o_valid));
    cmp("idle illegal", 8'h00, 8'(o_illegal));
    cmp("held clocks", 8'h03, 8'(o_decode.clocks));
  endtask : t_double
  task automatic print_verdict;
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(negedge i_sys_clk);
    i_reset = 1'b0;
    t_sub_ops();
    t_counts();
    t_reset();
    t_and();
    t_double();
    print_verdict();
  end
  // about 32 transfers; far below this span
  initial begin
    #20000;
    errors++;
    print_verdict();
  end
endmodule : shift_rotate_decode_timing_tb
`default_nettype wire
